/* hw/tbsl_pkg.sv */
package tbsl_pkg;
   // ---------------------------------------------------------------
   // register map (word aligned byte offsets)
   // ---------------------------------------------------------------
   localparam logic [7:0]  REG_SEC_CFG    = 8'h00;  // tile_security_config
   localparam logic [7:0]  REG_CTRL       = 8'h04;  // boot control
   localparam logic [7:0]  REG_STATUS     = 8'h08;  // boot status
   localparam logic [7:0]  REG_CRC        = 8'h0C;  // computed crc
   localparam logic [7:0]  REG_LEN        = 8'h10;  // image length in words
   localparam logic [7:0]  REG_CHECK      = 8'h14;  // received check word
   // ---------------------------------------------------------------
   // security word fields
   // ---------------------------------------------------------------
   localparam int          SEC_JTAG_OFF   = 0;
   localparam int          SEC_LINK_OFF   = 1;
   localparam int          SEC_SECURE     = 5;
   localparam int          SEC_REDUND     = 7;
   localparam int          SEC_LOCK_LO    = 8;
   localparam int          SEC_MASTER     = 12;
   localparam int          SEC_JTAG_OTP   = 13;
   localparam int          SEC_DBG_OFF    = 14;
   localparam int          SEC_GP_LO      = 15;
   localparam int          SEC_GP_HI      = 21;
   localparam int          SEC_UC_LO      = 22;
   localparam logic [31:0] SEC_GP_MASK    = 32'h003F_8000;  // bits 21..15 general purpose, read only over the bus
   // ---------------------------------------------------------------
   // otp geometry and image format
   // ---------------------------------------------------------------
   localparam int          OTP_SECTORS    = 4;
   localparam int          OTP_ROWS       = 512;
   localparam int          OTP_AW         = 11;
   localparam logic [10:0] OTP_SEC_ROW    = 11'h7FF;  // security word row
   localparam logic [31:0] CRC_POLY       = 32'hEDB8_8320;
   localparam logic [31:0] CRC_INIT       = 32'hFFFF_FFFF;
   localparam logic [31:0] NO_CRC_MAGIC   = 32'h0D15_AB1E;
   localparam logic [7:0]  STS_RESET      = 8'h00;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int          CLK_MHZ        = 40;
   localparam int          RST_SEQ_US     = 15;  // least internal reset time
   localparam int          RST_SEQ_CYC    = RST_SEQ_US * CLK_MHZ;
   // boot sequencer states
   typedef enum logic [8:0] {
      ST_RESET  = 9'h001,
      ST_SECRD  = 9'h002,
      ST_SECWT  = 9'h004,
      ST_HEAD   = 9'h008,
      ST_BODY   = 9'h010,
      ST_CHECK  = 9'h020,
      ST_VERIFY = 9'h040,
      ST_RUN    = 9'h080,
      ST_ERROR  = 9'h100
   } tbsl_state_t;
endpackage : tbsl_pkg

/* hw/tbsl_loader.sv */
// Functional notes
// R01: held in reset while chip reset low
// R02: pull-downs on all gpio in reset
// R03: boot starts 15 to 150 us after release
// R04: security bit 5 selects otp, else flash
// R05: secure boot starts at otp address 0
// R06: image is length, s words, check word
// R07: magic check word skips crc check
// R08: length and check word lsb first
// R09: load at sram 0, run from 0
// R10: crc over length and program bytes
// R11: reflected crc 0xEDB88320, init ones, inverted
// R12: security word loaded from otp first
// R13: further otp content copied and executed
// R14: otp is four sectors of 512 rows
// R15: bit 0 blocks jtag tile access
// R16: bit 1 blocks switch access to state
// R17: bit 7 enables redundant otp rows
// R18: bits 8..11 lock sectors 0..3
// R19: bit 12 inhibits all otp programming
// R20: bit 13 blocks jtag otp access
// R21: bit 14 disables debug sync pin
// R22: bits 15..21 gp, 22..31 usercode extension
// R23: crc mismatch holds tile in error
//
// Our own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/100ps
module tbsl_loader #(
   parameter int GPIO_W  = 16,
   parameter int SRAM_AW = 15,
   parameter int RST_CYC = tbsl_pkg::RST_SEQ_CYC
) (
   // clock and reset
   input  wire logic                      i_core_clk,
   input  wire logic                      i_srst,
   input  wire logic                      i_chip_rst_n,
   // wishbone slave
   input  wire logic                      i_wb_cyc,
   input  wire logic                      i_wb_stb,
   input  wire logic                      i_wb_we,
   input  wire logic [7:0]                i_wb_adr,
   input  wire logic [3:0]                i_wb_sel,
   input  wire logic [31:0]               i_wb_dat,
   output logic      [31:0]               o_wb_dat,
   output logic                           o_wb_ack,
   // flash byte stream
   output logic                           o_fl_req,
   input  wire logic                      i_fl_vld,
   input  wire logic [7:0]                i_fl_byte,
   // otp read port
   output logic                           o_otp_rd,
   output logic      [tbsl_pkg::OTP_AW-1:0] o_otp_addr,
   output logic                           o_otp_redund,
   input  wire logic                      i_otp_vld,
   input  wire logic [31:0]               i_otp_data,
   // sram write port
   output logic                           o_sram_we,
   output logic      [SRAM_AW-1:0]        o_sram_addr,
   output logic      [7:0]                o_sram_byte,
   // tile control and protection
   output logic                           o_tile_rst,
   output logic                           o_tile_run,
   output logic      [31:0]               o_tile_pc,
   output logic                           o_gpio_pd,
   output logic      [GPIO_W-1:0]         o_gpio_pd_en,
   output logic                           o_jtag_block,
   output logic                           o_link_block,
   output logic                           o_jtag_otp_block,
   output logic                           o_debug_pin_off,
   output logic      [tbsl_pkg::OTP_SECTORS-1:0] o_otp_prog_lock,
   output logic      [9:0]                o_usercode_ext
);
   import tbsl_pkg::*;

   // ---------------------------------------------------------------
   // crc helper
   // ---------------------------------------------------------------
   function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
      logic [31:0] r;
      r = c ^ {24'h000000, b};
      for (int k = 0; k < 8; k++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction : crc_byte

   tbsl_state_t   state_q;
   logic [12:0]   dly_q;
   logic [31:0]   sec_q;
   logic [31:0]   crc_q;
   logic [31:0]   len_q;
   logic [31:0]   chk_q;
   logic [31:0]   cnt_q;
   logic [1:0]    bidx_q;
   logic [31:0]   word_q;
   logic          word_vld_q;
   logic          use_otp_q;
   logic [OTP_AW-1:0] oaddr_q;
   logic          rd_pend_q;
   logic          boot_hold_q;
   logic [7:0]    byte_in;
   logic          byte_vld;
   logic          in_rst;
   logic [31:0]   prog_bytes;

   // R01: chip reset holds device
   assign in_rst     = i_srst | ~i_chip_rst_n;
   assign prog_bytes = {len_q[29:0], 2'b00};

   // ---------------------------------------------------------------
   // byte source: flash stream or otp words split lsb first
   // ---------------------------------------------------------------
   // R04: source select by bit 5
   always_comb begin
      if (use_otp_q) begin
         byte_vld = word_vld_q;
         byte_in  = word_q[8*bidx_q +: 8];
      end else begin
         byte_vld = i_fl_vld & o_fl_req;
         byte_in  = i_fl_byte;
      end
   end

   // otp word fetch and byte split
   always_ff @(posedge i_core_clk) begin
      if (in_rst) begin
         word_vld_q <= 1'b0;
         word_q     <= 32'h0000_0000;
         bidx_q     <= 2'b00;
         rd_pend_q  <= 1'b0;
         o_otp_rd   <= 1'b0;
         oaddr_q    <= '0;
      end else begin
         o_otp_rd <= 1'b0;
         if (state_q == ST_SECRD) begin
            // R12: fetch security word row
            o_otp_rd  <= 1'b1;
            oaddr_q   <= OTP_SEC_ROW;
            rd_pend_q <= 1'b1;
         end else if (state_q == ST_SECWT) begin
            if (i_otp_vld) begin
               rd_pend_q <= 1'b0;
               // R05: image begins at otp row 0
               oaddr_q   <= '0;
            end
         end else if (use_otp_q && (state_q == ST_HEAD || state_q == ST_BODY || state_q == ST_CHECK)) begin
            if (!word_vld_q && !rd_pend_q) begin
               // R13: rest of otp copied in
               o_otp_rd  <= 1'b1;
               rd_pend_q <= 1'b1;
            end else if (rd_pend_q && i_otp_vld) begin
               rd_pend_q  <= 1'b0;
               word_q     <= i_otp_data;
               word_vld_q <= 1'b1;
               bidx_q     <= 2'b00;
               oaddr_q    <= oaddr_q + 11'h001;
            end else if (word_vld_q) begin
               // R08: low byte first
               bidx_q <= bidx_q + 2'b01;
               if (bidx_q == 2'b11) begin
                  word_vld_q <= 1'b0;
               end
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // boot sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (in_rst) begin
         state_q     <= ST_RESET;
         dly_q       <= '0;
         sec_q       <= 32'h0000_0000;
         use_otp_q   <= 1'b0;
         crc_q       <= CRC_INIT;
         len_q       <= 32'h0000_0000;
         chk_q       <= 32'h0000_0000;
         cnt_q       <= 32'h0000_0000;
         o_sram_we   <= 1'b0;
         o_sram_addr <= '0;
         o_sram_byte <= 8'h00;
         o_fl_req    <= 1'b0;
         o_tile_run  <= 1'b0;
         o_tile_pc   <= 32'h0000_0000;
      end else begin
         o_sram_we <= 1'b0;
         case (state_q)
            // R03: internal reset delay
            ST_RESET: begin
               dly_q <= dly_q + 13'h0001;
               if (int'(dly_q) >= RST_CYC - 1) begin
                  state_q <= ST_SECRD;
               end
            end
            ST_SECRD: state_q <= ST_SECWT;
            ST_SECWT: begin
               if (i_otp_vld) begin
                  sec_q     <= i_otp_data;
                  use_otp_q <= i_otp_data[SEC_SECURE];
                  o_fl_req  <= ~i_otp_data[SEC_SECURE];
                  cnt_q     <= 32'h0000_0000;
                  state_q   <= ST_HEAD;
               end
            end
            // R06: length word first
            ST_HEAD: begin
               if (byte_vld) begin
                  // R10: length covered by crc
                  crc_q <= crc_byte(crc_q, byte_in);
                  // R08: assemble lsb first
                  len_q <= {byte_in, len_q[31:8]};
                  cnt_q <= cnt_q + 32'h0000_0001;
                  if (cnt_q == 32'h0000_0003) begin
                     cnt_q   <= 32'h0000_0000;
                     state_q <= ({byte_in, len_q[31:8]} == 32'h0000_0000) ? ST_CHECK : ST_BODY;
                  end
               end
            end
            ST_BODY: begin
               if (byte_vld) begin
                  // R10: program bytes in crc
                  crc_q <= crc_byte(crc_q, byte_in);
                  // R09: copy from lowest sram
                  o_sram_we   <= 1'b1;
                  o_sram_addr <= cnt_q[SRAM_AW-1:0];
                  o_sram_byte <= byte_in;
                  cnt_q       <= cnt_q + 32'h0000_0001;
                  if (cnt_q == prog_bytes - 32'h0000_0001) begin
                     cnt_q   <= 32'h0000_0000;
                     state_q <= ST_CHECK;
                  end
               end
            end
            ST_CHECK: begin
               if (byte_vld) begin
                  // R08: check word lsb first
                  chk_q <= {byte_in, chk_q[31:8]};
                  cnt_q <= cnt_q + 32'h0000_0001;
                  if (cnt_q == 32'h0000_0003) begin
                     o_fl_req <= 1'b0;
                     state_q  <= ST_VERIFY;
                  end
               end
            end
            ST_VERIFY: begin
               // R07: magic skips check
               // R11: inverted residue compared
               if (chk_q == NO_CRC_MAGIC || chk_q == ~crc_q) begin
                  state_q <= ST_RUN;
               end else begin
                  // R23: mismatch holds error
                  state_q <= ST_ERROR;
               end
            end
            ST_RUN: begin
               // R09: start at address 0
               o_tile_pc  <= 32'h0000_0000;
               o_tile_run <= ~boot_hold_q;
            end
            ST_ERROR: o_tile_run <= 1'b0;
            default:  state_q <= ST_RESET;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // pins and protection outputs
   // ---------------------------------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (in_rst) begin
         // R02: pull-downs while in reset
         o_gpio_pd        <= 1'b1;
         o_gpio_pd_en     <= '1;
         o_tile_rst       <= 1'b1;
         o_jtag_block     <= 1'b0;
         o_link_block     <= 1'b0;
         o_jtag_otp_block <= 1'b0;
         o_debug_pin_off  <= 1'b0;
         o_otp_prog_lock  <= '0;
         o_otp_redund     <= 1'b0;
         o_usercode_ext   <= 10'h000;
         o_otp_addr       <= '0;
      end else begin
         o_gpio_pd        <= 1'b0;
         o_gpio_pd_en     <= '0;
         o_tile_rst       <= (state_q != ST_RUN);
         o_otp_addr       <= (state_q == ST_SECRD) ? OTP_SEC_ROW : oaddr_q;
         // R15: jtag tile block
         o_jtag_block     <= sec_q[SEC_JTAG_OFF];
         // R16: switch access block
         o_link_block     <= sec_q[SEC_LINK_OFF];
         // R17: redundant rows
         o_otp_redund     <= sec_q[SEC_REDUND];
         // R14: four sector locks
         // R18: per sector lock
         // R19: master lock covers all
         o_otp_prog_lock  <= sec_q[SEC_LOCK_LO +: OTP_SECTORS] | {OTP_SECTORS{sec_q[SEC_MASTER]}};
         // R20: jtag otp block
         o_jtag_otp_block <= sec_q[SEC_JTAG_OTP];
         // R21: debug pin off
         o_debug_pin_off  <= sec_q[SEC_DBG_OFF];
         // R22: usercode extension
         o_usercode_ext   <= sec_q[31:SEC_UC_LO];
      end
   end

   // ---------------------------------------------------------------
   // wishbone slave: one wait state, ack one cycle
   // ---------------------------------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (in_rst) begin
         o_wb_ack    <= 1'b0;
         o_wb_dat    <= 32'h0000_0000;
         boot_hold_q <= 1'b0;
      end else begin
         o_wb_ack <= i_wb_cyc & i_wb_stb & ~o_wb_ack;
         // control write lands on the edge that carries ack
         if (i_wb_cyc && i_wb_stb && o_wb_ack && i_wb_we && i_wb_adr == REG_CTRL && i_wb_sel[0]) begin
            boot_hold_q <= i_wb_dat[0];
         end
         if (i_wb_cyc && i_wb_stb && !o_wb_ack) begin
            case (i_wb_adr)
               REG_SEC_CFG: o_wb_dat <= sec_q;
               REG_CTRL:    o_wb_dat <= {31'h0000_0000, boot_hold_q};
               REG_STATUS:  o_wb_dat <= {23'h000000, state_q};
               REG_CRC:     o_wb_dat <= ~crc_q;
               REG_LEN:     o_wb_dat <= len_q;
               REG_CHECK:   o_wb_dat <= chk_q;
               default:     o_wb_dat <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule : tbsl_loader

/* testbench/tbsl_loader_asserts.sv */
`timescale 1ns/100ps
module tbsl_loader_asserts
   import tbsl_pkg::*;
#(
   parameter int GPIO_W  = 16,
   parameter int SRAM_AW = 15,
   parameter int RST_CYC = RST_SEQ_CYC
) (
   // clock, resets and handshakes
   input wire logic                  i_core_clk, i_srst, i_chip_rst_n, i_wb_cyc, i_wb_stb, o_wb_ack,
   input wire logic                  i_otp_vld, o_otp_rd, o_fl_req, o_sram_we,
   // data and addresses
   input wire logic [31:0]           i_otp_data, o_tile_pc,
   input wire logic [OTP_AW-1:0]     o_otp_addr,
   input wire logic [SRAM_AW-1:0]    o_sram_addr,
   // tile control and protection
   input wire logic                  o_tile_rst, o_tile_run, o_gpio_pd, o_otp_redund,
   input wire logic                  o_jtag_block, o_link_block, o_jtag_otp_block, o_debug_pin_off,
   input wire logic [GPIO_W-1:0]     o_gpio_pd_en,
   input wire logic [OTP_SECTORS-1:0] o_otp_prog_lock,
   input wire logic [9:0]            o_usercode_ext
);
   wire                rst = i_srst | ~i_chip_rst_n;
   int                 cnt_q;
   logic               seen_rd_q, seen_we_q, sec_vld_q;
   logic [31:0]        sec_q;
   logic [SRAM_AW-1:0] last_q;
   // cycles since release, first read and write, captured security word
   always_ff @(posedge i_core_clk) begin
      if (rst) begin
         cnt_q <= 0;
         seen_rd_q <= 1'b0;
         seen_we_q <= 1'b0;
         sec_vld_q <= 1'b0;
         sec_q <= '0;
         last_q <= '0;
      end else begin
         if (cnt_q < RST_CYC) cnt_q <= cnt_q + 1;
         if (o_otp_rd) seen_rd_q <= 1'b1;
         if (o_sram_we) seen_we_q <= 1'b1;
         if (o_sram_we) last_q <= o_sram_addr;
         if (i_otp_vld && o_otp_addr == OTP_SEC_ROW) sec_q <= i_otp_data;
         if (i_otp_vld && o_otp_addr == OTP_SEC_ROW) sec_vld_q <= 1'b1;
      end
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (rst);
   in_reset_a: assert property (disable iff (1'b0) rst |=> o_tile_rst && !o_tile_run && o_gpio_pd && &o_gpio_pd_en)
      else $error("outputs wrong during reset");
   boot_delay_a: assert property (o_otp_rd |-> cnt_q >= RST_CYC)
      else $error("boot began before reset sequence");
   sec_first_a: assert property (o_otp_rd && !seen_rd_q |=> o_otp_addr == OTP_SEC_ROW)
      else $error("first read is not the security row");
   flash_src_a: assert property (o_fl_req |-> sec_vld_q && !sec_q[SEC_SECURE])
      else $error("flash used while otp boot selected");
   sram_base_a: assert property (o_sram_we && !seen_we_q |-> o_sram_addr == '0)
      else $error("first sram write not at address 0");
   sram_step_a: assert property (o_sram_we && seen_we_q |-> o_sram_addr == last_q + 1'b1)
      else $error("sram address not incrementing");
   run_pc_a: assert property ($rose(o_tile_run) |-> o_tile_pc == '0 && sec_vld_q)
      else $error("start without security word or pc 0");
   guard_bits_a: assert property (o_tile_run |-> {o_jtag_block, o_link_block, o_jtag_otp_block, o_debug_pin_off} ==
      {sec_q[SEC_JTAG_OFF], sec_q[SEC_LINK_OFF], sec_q[SEC_JTAG_OTP], sec_q[SEC_DBG_OFF]}) else $error("guard bits wrong");
   otp_lock_a: assert property (o_tile_run |-> o_otp_prog_lock == (sec_q[11:8] | {4{sec_q[SEC_MASTER]}}) &&
      o_otp_redund == sec_q[SEC_REDUND]) else $error("otp lock bits wrong");
   user_ext_a: assert property (o_tile_run |-> o_usercode_ext == sec_q[31:22])
      else $error("usercode extension wrong");
   wb_answer_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
      else $error("bus answer not a one cycle ack");
   cover property ($rose(o_tile_run));
   cover property (o_sram_we && o_sram_addr == '0);
   cover property (o_otp_rd && sec_vld_q && sec_q[SEC_SECURE]);
endmodule : tbsl_loader_asserts

bind tbsl_loader tbsl_loader_asserts #(.GPIO_W(GPIO_W), .SRAM_AW(SRAM_AW), .RST_CYC(RST_CYC)) u_asserts (
   .i_core_clk, .i_srst, .i_chip_rst_n, .i_wb_cyc, .i_wb_stb, .o_wb_ack, .i_otp_vld, .o_otp_rd, .o_fl_req,
   .o_sram_we, .i_otp_data, .o_tile_pc, .o_otp_addr, .o_sram_addr, .o_tile_rst, .o_tile_run, .o_gpio_pd,
   .o_otp_redund, .o_jtag_block, .o_link_block, .o_jtag_otp_block, .o_debug_pin_off, .o_gpio_pd_en,
   .o_otp_prog_lock, .o_usercode_ext);

/* testbench/tbsl_store_model.sv */
`timescale 1ns/100ps
module tbsl_store_model (
   // clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_rst,
   // flash byte stream
   input  wire logic        i_fl_req,
   output logic             o_fl_vld,
   output logic [7:0]       o_fl_byte,
   // otp read port
   input  wire logic        i_otp_rd,
   input  wire logic [10:0] i_otp_addr,
   output logic             o_otp_vld,
   output logic [31:0]      o_otp_data
);
   logic [31:0] otp [0:2047];
   logic [7:0]  flash [0:255];
   int          fl_ptr, otp_wait;
   // quiet outputs at time zero
   initial begin
      o_fl_vld = 1'b0;
      o_otp_vld = 1'b0;
      o_fl_byte = 8'hA5;
      o_otp_data = 32'h5A5A_A5A5;
   end
   // answers with random stalls, released data inverted
   always @(posedge i_core_clk) begin
      o_fl_vld <= 1'b0;
      o_otp_vld <= 1'b0;
      if (o_fl_vld) o_fl_byte <= ~o_fl_byte;
      if (o_otp_vld) o_otp_data <= ~o_otp_data;
      if (i_rst) begin
         fl_ptr <= 0;
         otp_wait <= 0;
      end else begin
         if (i_fl_req && !o_fl_vld && $urandom_range(0, 2) != 0) begin
            o_fl_vld <= 1'b1;
            o_fl_byte <= flash[fl_ptr];
            fl_ptr <= fl_ptr + 1;
         end
         if (i_otp_rd) otp_wait <= 2 + $urandom_range(0, 3);
         else if (otp_wait > 1) otp_wait <= otp_wait - 1;
         else if (otp_wait == 1) begin
            otp_wait <= 0;
            o_otp_vld <= 1'b1;
            o_otp_data <= otp[i_otp_addr];
         end
      end
   end
endmodule : tbsl_store_model

/* testbench/tile_boot_security_loader_bench.sv */
`timescale 1ns/100ps
module tile_boot_security_loader_bench;
   import tbsl_pkg::*;
   // design pins
   logic        i_core_clk = 1'b0, i_srst = 1'b1, i_chip_rst_n = 1'b1, i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
   logic [7:0]  i_wb_adr = 8'h00, i_fl_byte, o_sram_byte;
   logic [3:0]  i_wb_sel = 4'hF, o_otp_prog_lock;
   logic [31:0] i_wb_dat = 32'h0, o_wb_dat, i_otp_data, o_tile_pc, rd;
   logic        o_wb_ack, o_fl_req, i_fl_vld, o_otp_rd, o_otp_redund, i_otp_vld, o_sram_we, o_tile_rst, o_tile_run;
   logic        o_gpio_pd, o_jtag_block, o_link_block, o_jtag_otp_block, o_debug_pin_off;
   logic [10:0] o_otp_addr;
   logic [14:0] o_sram_addr;
   logic [15:0] o_gpio_pd_en;
   logic [9:0]  o_usercode_ext;
   logic [7:0]  exp_q[$];
   int          error_cnt = 0, checked = 0, n_wr = 0;

   tbsl_loader #(.RST_CYC(4)) dut (.*);
   tbsl_store_model mem (.i_core_clk, .i_rst(i_srst | ~i_chip_rst_n), .i_fl_req(o_fl_req), .o_fl_vld(i_fl_vld),
      .o_fl_byte(i_fl_byte), .i_otp_rd(o_otp_rd), .i_otp_addr(o_otp_addr), .o_otp_vld(i_otp_vld), .o_otp_data(i_otp_data));

   // 40 MHz clock
   always #12.5 i_core_clk = ~i_core_clk;

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk32

   task automatic test_done();
      $display("compares %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : test_done

   // one classic bus cycle, read data left in rd
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      int n;
      n = 0;
      @(posedge i_core_clk);
      i_wb_cyc <= 1'b1;
      i_wb_stb <= 1'b1;
      i_wb_we <= we;
      i_wb_adr <= adr;
      i_wb_dat <= dat;
      do begin
         @(posedge i_core_clk);
         n++;
      end while (o_wb_ack !== 1'b1 && n < 20);
      rd = o_wb_dat;
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
      if (n >= 20) chk32(32'h0, 32'h1);
      if (n >= 20) test_done();
   endtask : wb

   // every sram write against the next expected image byte
   always @(posedge i_core_clk) begin
      if (o_sram_we === 1'b1) begin
         chk32({o_sram_addr, o_sram_byte}, {n_wr[14:0], exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX});
         n_wr++;
      end
   end

   // reset, store an image, boot and compare; mode 0 crc, 1 magic, 2 bad crc
   task automatic boot(input logic [31:0] sec, input int s, input int mode, input bit chip);
      logic [7:0]  b[$];
      logic [31:0] crc, chk;
      int          k;
      if (chip) i_chip_rst_n <= 1'b0;
      else i_srst <= 1'b1;
      b = {};
      for (k = 0; k < 4 + 4 * s; k++) b.push_back(k < 4 ? s[8*k+:8] : 8'($urandom));
      exp_q = b[4:$];
      n_wr = 0;
      crc = 32'hFFFF_FFFF;
      foreach (b[i]) begin
         crc ^= {24'h0, b[i]};
         repeat (8) crc = crc[0] ? (crc >> 1) ^ 32'hEDB8_8320 : crc >> 1;
      end
      crc = ~crc;
      chk = (mode == 1) ? NO_CRC_MAGIC : crc ^ {31'h0, mode == 2};
      for (k = 0; k < 4; k++) b.push_back(chk[8*k+:8]);
      foreach (b[i]) mem.flash[i] = sec[5] ? ~b[i] : b[i];
      for (k = 0; k < b.size(); k += 4) mem.otp[k/4] = {b[k+3], b[k+2], b[k+1], b[k]} ^ {32{~sec[5]}};
      mem.otp[11'h7FF] = sec;
      repeat (20) @(posedge i_core_clk);
      chk32({o_gpio_pd_en, o_gpio_pd, o_tile_rst, o_tile_run}, {16'hFFFF, 3'b110});
      i_srst <= 1'b0;
      i_chip_rst_n <= 1'b1;
      k = 0;
      do begin
         wb(1'b0, REG_STATUS, 32'h0);
         k++;
      end while (rd !== 32'h80 && rd !== 32'h100 && k < 300);
      chk32(rd, mode == 2 ? 32'h100 : 32'h80);
      if (k >= 300) test_done();
      // hold bit parks a loaded tile, clearing it lets it run again
      wb(1'b1, REG_CTRL, 32'h0000_0001);
      wb(1'b0, REG_CTRL, 32'h0000_0000);
      chk32({rd[0], o_tile_run}, 2'b10);
      wb(1'b1, REG_CTRL, 32'h0000_0000);
      wb(1'b0, REG_LEN, 32'h0);
      chk32(rd, s);
      wb(1'b0, REG_CHECK, 32'h0);
      chk32(rd, chk);
      wb(1'b0, REG_CRC, 32'h0);
      chk32(rd, crc);
      wb(1'b0, REG_SEC_CFG, 32'h0);
      chk32(rd, sec);
      wb(1'b1, 8'h40, 32'hFFFF_FFFF);
      wb(1'b0, 8'h40, 32'h0);
      chk32(rd, 32'h0);
      chk32(n_wr, 4 * s);
      chk32(o_tile_pc, 32'h0);
      chk32({o_gpio_pd_en, o_gpio_pd, o_tile_run, o_tile_rst}, mode == 2 ? 32'h1 : 32'h2);
      chk32({o_usercode_ext, o_debug_pin_off, o_jtag_otp_block, o_otp_prog_lock, o_otp_redund, o_link_block, o_jtag_block},
            {sec[31:22], sec[14:13], sec[11:8] | {4{sec[12]}}, sec[7], sec[1:0]});
   endtask : boot

   // flash and otp boots, all three check outcomes, both resets
   initial begin
      int n;
      void'($urandom(32'hE7B4F7B1));
      for (n = 0; n < 6; n++) boot(($urandom & ~32'h20) | {26'h0, n[0], 5'h0}, (n * 5) % 7, n % 3, n[1]);
      test_done();
   end
endmodule : tile_boot_security_loader_bench
